//--- uart_core.sv
// serial port with baud generator, modem control and host register port
//
// Overview of operation
// - baud generator sets both tx and rx rates
// - data bit zero goes first on wire
// - line high is one, low is zero
// - loop-back feeds transmitter into receiver internally
// - frame: start, data, optional parity, stop bits
// - serial out high in reset, loop, disabled
// - strobes ignored while chip select high
// - write strobe loads addressed register
// - read strobe drives data, else bus released
// - interrupt high on enabled pending source
// - address code picks register per direction
// - divisor bytes share codes zero and one
// - modem bit one drives rts low
// - modem bit zero drives dtr low
// - cts readable in modem status bit four
// - dsr, ring, carrier are status only
// - master reset clears host registers, line idle
// - reset output follows modem bit two, held high in master reset
// - character length five to eight bits
// - even, odd or no parity
// - fast clock reaches top baud rate
// - one clock runs logic and baud generator
// - divisor writable only with access bit, never readable
// - baud tick is sixteen times bit rate
// - start bit rechecked seven and half ticks
// - interrupt released unless modem bit three
`timescale 1ns/1ps
module uart_core
  import uart_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            request_to_send_n,
  output logic            terminal_ready_n,
  input  wire logic       clear_to_send_n,
  input  wire logic       data_set_ready_n,
  input  wire logic       ring_indicator_n,
  input  wire logic       carrier_detect_n,
  output logic            irq_out,
  output logic            irq_oe_n,
  output logic            soft_reset_out
);

  // whole block state in one record
  typedef struct packed {
    logic [3:0]   interrupt_enable;        // irq enables
    logic [7:0]   line_control;        // line control
    logic [4:0]   modem_control;        // modem control
    logic [7:0]   scratch;    // scratch byte
    logic [15:0]  div;        // baud divisor
    logic [15:0]  baud_cnt;   // divisor down counter
    logic         tick;       // 16x tick
    logic [7:0]   transmit_buffer;        // transmit buffer
    logic         thr_empty;  // buffer free
    logic         thre_irq;   // tx empty event pending
    logic [7:0]   tsr;        // tx shifter
    logic         tx_par;     // parity bit for the frame
    tx_phase_type tx_phase;
    logic [4:0]   tx_cnt;     // ticks within a bit
    logic [2:0]   tx_bit;     // data bit index
    logic         tx_line;    // raw tx level
    logic         rx_prev;    // previous rx level
    rx_phase_type rx_phase;
    logic [4:0]   rx_cnt;
    logic [2:0]   rx_bit;
    logic [7:0]   rx_shift;   // rx shifter, fills from top
    logic         rx_acc;     // running xor of data
    logic         rx_zero;    // all bits low so far
    logic         rx_perr;    // parity mismatch in frame
    logic [7:0]   rbr;        // receive buffer
    logic         data_ready;
    logic         overrun;
    logic         par_err;
    logic         frm_err;
    logic         brk;
    logic [3:0]   modem_prev; // cd, ri, dsr, cts active high
    logic [3:0]   delta;      // modem change flags
    logic         wr_prev;    // write request seen last cycle (low)
    logic         rd_prev;
    logic         rd_active;  // read in progress, data valid
    logic [7:0]   data_out;
    logic         serial_out;
    logic         irq;
    logic         rst_out;
  } state_type;

  // reset image: line idle, tx buffer empty, strobes idle
  localparam state_type STATE_RESET = '{
    thr_empty: 1'b1, tx_line: 1'b1, rx_prev: 1'b1, wr_prev: 1'b1,
    rd_prev: 1'b1, serial_out: 1'b1, rst_out: 1'b1,
    tx_phase: TX_IDLE, rx_phase: RX_IDLE, default: '0};

  state_type  state_reg;   // registered state
  state_type  state_next;  // next state
  logic       wr_req_n;    // qualified write request
  logic       rd_req_n;    // qualified read request
  logic       wr_edge;     // first cycle of a write
  logic       rd_edge;     // first cycle of a read
  logic       rx_in;       // receiver input after loop mux
  logic       tx_wire;     // transmitter level incl. break
  logic [3:0] modem_now;   // modem inputs or loop image
  logic [2:0] wlen_last;   // last data bit index
  logic [4:0] stop_last;   // last tick index of stop bits
  logic [7:0] line_status;         // line status image
  logic [7:0] modem_status;         // modem status image
  logic [7:0] interrupt_status;         // interrupt status image
  logic       line_int;
  logic       rx_int;
  logic       tx_int;
  logic       ms_int;

  // strobes count only with chip select low
  assign wr_req_n = cs_n | write_strobe_n;
  assign rd_req_n = cs_n | read_strobe_n;
  assign wr_edge  = !wr_req_n && state_reg.wr_prev;
  assign rd_edge  = !rd_req_n && state_reg.rd_prev;

  // loop mux; break forces the transmitter low
  assign tx_wire = state_reg.line_control[LCR_BREAK] ? 1'b0 : state_reg.tx_line;
  assign rx_in   = state_reg.modem_control[MCR_LOOP] ? tx_wire : serial_in;

  // modem inputs only feed status, never the data paths
  assign modem_now = state_reg.modem_control[MCR_LOOP] ?
    {state_reg.modem_control[MCR_IRQ_EN], state_reg.modem_control[MCR_SOFT_RST],
     state_reg.modem_control[MCR_DTR], state_reg.modem_control[MCR_RTS]} :
    ~{carrier_detect_n, ring_indicator_n, data_set_ready_n,
      clear_to_send_n};

  // frame format from line control
  assign wlen_last = WLEN_BASE + 3'(state_reg.line_control[1:0]);
  always_comb
  begin
    if (!state_reg.line_control[LCR_STOP])
      stop_last = STOP1_LAST;
    else if (state_reg.line_control[1:0] == 2'h0)
      stop_last = STOP15_LAST;
    else
      stop_last = STOP2_LAST;
  end

  // status images
  assign line_status = {1'b0, state_reg.thr_empty && state_reg.tx_phase == TX_IDLE,
                state_reg.thr_empty, state_reg.brk, state_reg.frm_err,
                state_reg.par_err, state_reg.overrun, state_reg.data_ready};
  assign modem_status = {modem_now, state_reg.delta};

  // interrupt sources and priority
  assign line_int = state_reg.interrupt_enable[2] && (state_reg.overrun ||
    state_reg.par_err || state_reg.frm_err || state_reg.brk);
  assign rx_int = state_reg.interrupt_enable[0] && state_reg.data_ready;
  assign tx_int = state_reg.interrupt_enable[1] && state_reg.thre_irq;
  assign ms_int = state_reg.interrupt_enable[3] && (state_reg.delta != 4'h0);
  always_comb
  begin
    if (line_int)
      interrupt_status = ISR_LINE;
    else if (rx_int)
      interrupt_status = ISR_RX;
    else if (tx_int)
      interrupt_status = ISR_TX;
    else if (ms_int)
      interrupt_status = ISR_MODEM;
    else
      interrupt_status = ISR_NONE;
  end

  // next state: host side first so hardware sets override clears
  always_comb
  begin
    state_next = state_reg;
    state_next.wr_prev = wr_req_n;
    state_next.rd_prev = rd_req_n;
    state_next.rd_active = !rd_req_n;
    state_next.tick = 1'b0;

    // host writes, decoded per address and access bit
    if (wr_edge)
    begin
      unique case (reg_addr)
        ADDR_BUFFER:
        begin
          if (state_reg.line_control[LCR_DIV_ACC])
            state_next.div[7:0] = host_data_in;
          else
          begin
            state_next.transmit_buffer = host_data_in;
            state_next.thr_empty = 1'b0;
            state_next.thre_irq = 1'b0;
          end
        end
        ADDR_IRQ_EN:
        begin
          if (state_reg.line_control[LCR_DIV_ACC])
            state_next.div[15:8] = host_data_in;
          else
            state_next.interrupt_enable = host_data_in[3:0];
        end
        ADDR_LINE_CTL:  state_next.line_control = host_data_in;
        ADDR_MODEM_CTL: state_next.modem_control = host_data_in[4:0];
        ADDR_SCRATCH:   state_next.scratch = host_data_in;
        default:
        begin
          // read-only codes ignore writes
        end
      endcase
    end

    // host reads: capture data once, apply read side effects
    if (rd_edge)
    begin
      unique case (reg_addr)
        ADDR_BUFFER:
        begin
          if (state_reg.line_control[LCR_DIV_ACC])
            state_next.data_out = 8'h00;
          else
          begin
            state_next.data_out = state_reg.rbr;
            state_next.data_ready = 1'b0;
          end
        end
        ADDR_IRQ_STAT:
        begin
          state_next.data_out = interrupt_status;
          if (interrupt_status == ISR_TX)
            state_next.thre_irq = 1'b0;
        end
        ADDR_LINE_STAT:
        begin
          state_next.data_out = line_status;
          state_next.overrun = 1'b0;
          state_next.par_err = 1'b0;
          state_next.frm_err = 1'b0;
          state_next.brk = 1'b0;
        end
        ADDR_MODEM_STAT:
        begin
          state_next.data_out = modem_status;
          state_next.delta = 4'h0;
        end
        ADDR_SCRATCH: state_next.data_out = state_reg.scratch;
        default:      state_next.data_out = 8'h00;
      endcase
    end

    // baud generator on the core clock; zero divisor stops it
    if (state_reg.div == 16'h0000)
      state_next.baud_cnt = 16'h0000;
    else if (state_reg.baud_cnt == 16'h0000)
    begin
      state_next.baud_cnt = state_reg.div - 16'h0001;
      state_next.tick = 1'b1;
    end
    else
      state_next.baud_cnt = state_reg.baud_cnt - 16'h0001;

    // transmitter, advanced on 16x ticks
    if (state_reg.tick)
    begin
      state_next.tx_cnt = state_reg.tx_cnt + 5'h01;
      unique case (state_reg.tx_phase)
        TX_IDLE:
        begin
          state_next.tx_cnt = 5'h00;
          if (!state_reg.thr_empty)
          begin
            state_next.tsr = state_reg.transmit_buffer;
            state_next.tx_par = state_reg.line_control[LCR_STICK] ?
              !state_reg.line_control[LCR_EVEN] :
              ((^(state_reg.transmit_buffer & ~(8'hFF << (4'(wlen_last) + 4'h1)))) ^
               !state_reg.line_control[LCR_EVEN]);
            state_next.thr_empty = 1'b1;
            state_next.thre_irq = 1'b1;
            state_next.tx_phase = TX_START;
            state_next.tx_line = 1'b0;
          end
        end
        TX_START:
        begin
          if (state_reg.tx_cnt == BIT_LAST)
          begin
            state_next.tx_cnt = 5'h00;
            state_next.tx_bit = 3'h0;
            state_next.tx_line = state_reg.tsr[0];
            state_next.tx_phase = TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (state_reg.tx_cnt == BIT_LAST)
          begin
            state_next.tx_cnt = 5'h00;
            if (state_reg.tx_bit == wlen_last)
            begin
              state_next.tx_phase = state_reg.line_control[LCR_PAR_EN] ?
                TX_PARITY : TX_STOP;
              state_next.tx_line = state_reg.line_control[LCR_PAR_EN] ?
                state_reg.tx_par : 1'b1;
            end
            else
            begin
              state_next.tx_bit = state_reg.tx_bit + 3'h1;
              state_next.tsr = state_reg.tsr >> 1;
              state_next.tx_line = state_reg.tsr[1];
            end
          end
        end
        TX_PARITY:
        begin
          if (state_reg.tx_cnt == BIT_LAST)
          begin
            state_next.tx_cnt = 5'h00;
            state_next.tx_line = 1'b1;
            state_next.tx_phase = TX_STOP;
          end
        end
        TX_STOP:
        begin
          if (state_reg.tx_cnt == stop_last)
          begin
            state_next.tx_cnt = 5'h00;
            state_next.tx_phase = TX_IDLE;
          end
        end
      endcase
    end

    // receiver: edge wakes it, ticks time the samples
    state_next.rx_prev = rx_in;
    unique case (state_reg.rx_phase)
      RX_IDLE:
      begin
        if (state_reg.rx_prev && !rx_in)
        begin
          state_next.rx_cnt = 5'h00;
          state_next.rx_phase = RX_START;
        end
      end
      RX_START:
      begin
        if (state_reg.tick)
        begin
          state_next.rx_cnt = state_reg.rx_cnt + 5'h01;
          if (state_reg.rx_cnt == START_SAMPLE)
          begin
            state_next.rx_cnt = 5'h00;
            state_next.rx_bit = 3'h0;
            state_next.rx_acc = 1'b0;
            state_next.rx_zero = 1'b1;
            state_next.rx_phase = rx_in ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (state_reg.tick)
        begin
          state_next.rx_cnt = state_reg.rx_cnt + 5'h01;
          if (state_reg.rx_cnt == BIT_LAST)
          begin
            state_next.rx_cnt = 5'h00;
            state_next.rx_shift = {rx_in, state_reg.rx_shift[7:1]};
            state_next.rx_acc = state_reg.rx_acc ^ rx_in;
            state_next.rx_zero = state_reg.rx_zero && !rx_in;
            state_next.rx_perr = 1'b0;
            state_next.rx_bit = state_reg.rx_bit + 3'h1;
            if (state_reg.rx_bit == wlen_last)
              state_next.rx_phase = state_reg.line_control[LCR_PAR_EN] ?
                RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY:
      begin
        if (state_reg.tick)
        begin
          state_next.rx_cnt = state_reg.rx_cnt + 5'h01;
          if (state_reg.rx_cnt == BIT_LAST)
          begin
            state_next.rx_cnt = 5'h00;
            state_next.rx_zero = state_reg.rx_zero && !rx_in;
            state_next.rx_perr = rx_in != (state_reg.line_control[LCR_STICK] ?
              !state_reg.line_control[LCR_EVEN] :
              (state_reg.rx_acc ^ !state_reg.line_control[LCR_EVEN]));
            state_next.rx_phase = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (state_reg.tick)
        begin
          state_next.rx_cnt = state_reg.rx_cnt + 5'h01;
          if (state_reg.rx_cnt == BIT_LAST)
          begin
            state_next.rx_cnt = 5'h00;
            state_next.rbr = state_reg.rx_shift >> (3'h7 - wlen_last);
            state_next.overrun = state_reg.overrun ||
              state_reg.data_ready;
            state_next.data_ready = 1'b1;
            state_next.par_err = state_reg.par_err || state_reg.rx_perr;
            state_next.frm_err = state_reg.frm_err || !rx_in;
            state_next.brk = state_reg.brk ||
              (state_reg.rx_zero && !rx_in);
            state_next.rx_phase = RX_IDLE;
          end
        end
      end
    endcase

    // modem change flags: ring counts only its trailing edge
    state_next.modem_prev = modem_now;
    state_next.delta = state_next.delta |
      {state_reg.modem_prev[3] ^ modem_now[3],
       state_reg.modem_prev[2] && !modem_now[2],
       state_reg.modem_prev[1:0] ^ modem_now[1:0]};

    // registered pins
    state_next.irq = interrupt_status != ISR_NONE;
    state_next.rst_out = state_next.modem_control[MCR_SOFT_RST];
    state_next.serial_out = state_next.modem_control[MCR_LOOP] ||
      (!state_next.line_control[LCR_BREAK] && state_next.tx_line);
  end

  // single state register; modem history taken from live pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= STATE_RESET;
      state_reg.modem_prev <= ~{carrier_detect_n, ring_indicator_n,
                                data_set_ready_n, clear_to_send_n};
    end
    else
      state_reg <= state_next;
  end

  // pins
  assign host_data_out     = state_reg.data_out;
  assign host_data_oe_n    = !(state_reg.rd_active && !rd_req_n);
  assign serial_out        = state_reg.serial_out;
  assign request_to_send_n = !state_reg.modem_control[MCR_RTS];
  assign terminal_ready_n  = !state_reg.modem_control[MCR_DTR];
  assign irq_out           = state_reg.irq;
  assign irq_oe_n          = !state_reg.modem_control[MCR_IRQ_EN];
  assign soft_reset_out    = state_reg.rst_out;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_start;
    rd_edge ##1 !rd_req_n;
  endsequence

  a_loop_mark_out: assert property (
    state_reg.modem_control[MCR_LOOP] |-> serial_out)
    else $error("serial out not mark in loop-back");
  a_rts_from_write: assert property (
    wr_edge && reg_addr == ADDR_MODEM_CTL
    |=> request_to_send_n == !$past(host_data_in[MCR_RTS]))
    else $error("rts does not follow modem control");
  a_dtr_from_write: assert property (
    wr_edge && reg_addr == ADDR_MODEM_CTL
    |=> terminal_ready_n == !$past(host_data_in[MCR_DTR]))
    else $error("dtr does not follow modem control");
  a_cs_blocks_write: assert property (
    cs_n |=> $stable(state_reg.scratch) && $stable(state_reg.line_control))
    else $error("register changed without chip select");
  a_scratch_store: assert property (
    wr_edge && reg_addr == ADDR_SCRATCH
    ##1 (rd_edge && reg_addr == ADDR_SCRATCH)
    |=> host_data_out == $past(host_data_in, 2))
    else $error("scratch did not keep written byte");
  a_read_drives_bus: assert property (
    read_start |-> !host_data_oe_n)
    else $error("bus not driven during read");
  a_idle_bus_released: assert property (
    rd_req_n |-> host_data_oe_n)
    else $error("bus driven without read");
  a_wo_reads_zero: assert property (
    rd_edge && reg_addr == ADDR_LINE_CTL |=> host_data_out == 8'h00)
    else $error("write-only code read nonzero");
  a_rx_irq_raise: assert property (
    state_reg.interrupt_enable[0] && state_reg.data_ready |=> irq_out)
    else $error("enabled rx data gave no interrupt");
  a_false_start: assert property (
    state_reg.rx_phase == RX_START && state_reg.tick &&
    state_reg.rx_cnt == START_SAMPLE && rx_in
    |=> state_reg.rx_phase == RX_IDLE)
    else $error("noise accepted as start bit");
  a_div_low_write: assert property (
    wr_edge && reg_addr == ADDR_BUFFER && state_reg.line_control[LCR_DIV_ACC]
    |=> state_reg.div[7:0] == $past(host_data_in) && $stable(state_reg.transmit_buffer))
    else $error("divisor low write misrouted");
  a_tick_period: assert property (
    state_reg.tick && state_reg.div == 16'h0003 && $stable(state_reg.div)
    |=> !state_reg.tick ##1 !state_reg.tick ##1 state_reg.tick)
    else $error("baud tick period wrong");

endmodule : uart_core

//--- uart_core_bench.sv
// self-checking bench of the serial port block
`timescale 1ns/1ps
module uart_core_bench;
  import uart_pkg::*;
  logic clk, rst, cs_n, read_strobe_n, write_strobe_n, serial_in, serial_out;
  logic [2:0] reg_addr;
  logic [7:0] host_data_in, host_data_out, caught;
  logic host_data_oe_n, request_to_send_n, terminal_ready_n, irq_out;
  logic clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n;
  logic irq_oe_n, soft_reset_out, lo;
  int mismatches, n_checks, cycles, n_caught;

  uart_core DUT (.clk, .rst, .cs_n, .read_strobe_n, .write_strobe_n,
    .reg_addr, .host_data_in, .host_data_out, .host_data_oe_n, .serial_in,
    .serial_out, .request_to_send_n, .terminal_ready_n, .clear_to_send_n,
    .data_set_ready_n, .ring_indicator_n, .carrier_detect_n, .irq_out,
    .irq_oe_n, .soft_reset_out);
  uart_line_model #(.BIT_CYC(48)) LINE (.clk(clk), .line_from_dut(serial_out),
    .line_to_dut(serial_in), .caught(caught), .n_caught(n_caught));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // one write access, then two idle cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cs_n <= 1'b0;
    write_strobe_n <= 1'b0;
    reg_addr <= a;
    host_data_in <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : wr

  // one read access; bus must be released after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    cs_n <= 1'b0;
    read_strobe_n <= 1'b0;
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 check("read data", e, host_data_out);
    check("bus driven", 8'h00, {7'h0, host_data_oe_n});
    @(posedge clk);
    cs_n <= 1'b1;
    read_strobe_n <= 1'b1;
    @(posedge clk);
    #1 check("bus released", 8'h01, {7'h0, host_data_oe_n});
  endtask : rd

  // pins: serial_out, rts_n, dtr_n, irq_oe_n, soft reset
  function automatic logic [7:0] pins();
    return {3'h0, serial_out, request_to_send_n, terminal_ready_n, irq_oe_n,
            soft_reset_out};
  endfunction : pins

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // hang guard, well beyond the roughly 1500 cycles of the tests
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    clk = 0; rst = 1; cs_n = 1; read_strobe_n = 1; write_strobe_n = 1;
    reg_addr = 3'h0; host_data_in = 8'h00; clear_to_send_n = 1;
    data_set_ready_n = 1; ring_indicator_n = 1; carrier_detect_n = 1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("reset pins", 8'h1E, pins());
    rd(ADDR_LINE_STAT, 8'h60);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_SCRATCH, 8'hA5);
    rd(ADDR_SCRATCH, 8'hA5);
    // write strobe while deselected must not land
    write_strobe_n <= 1'b0;
    host_data_in <= 8'h5A;
    repeat (2) @(posedge clk);
    write_strobe_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_SCRATCH, 8'hA5);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_LINE_CTL, 8'h00);
    wr(ADDR_MODEM_CTL, 8'h0F);
    #1 check("modem pins", 8'h11, pins());
    clear_to_send_n <= 1'b0;
    @(posedge clk);
    rd(ADDR_MODEM_STAT, 8'h11);
    rd(ADDR_MODEM_STAT, 8'h10);
    wr(ADDR_LINE_CTL, 8'h83);
    wr(ADDR_BUFFER, 8'h03);
    wr(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_BUFFER, 8'h00);
    wr(ADDR_LINE_CTL, 8'h03);
    wr(ADDR_BUFFER, 8'h5A);
    for (int k = 0; k < 2000 && n_caught == 0; k++) @(posedge clk);
    check("tx byte", 8'h5A, caught);
    wr(ADDR_IRQ_EN, 8'h01);
    LINE.send(8'h96);
    for (int k = 0; k < 200 && irq_out !== 1'b1; k++) @(posedge clk);
    #1 check("rx irq", 8'h01, {7'h0, irq_out});
    rd(ADDR_IRQ_STAT, 8'h04);
    rd(ADDR_LINE_STAT, 8'h61);
    rd(ADDR_BUFFER, 8'h96);
    #1 check("irq cleared", 8'h00, {7'h0, irq_out});
    // loop-back: byte must come back inside, line stays at mark
    wr(ADDR_MODEM_CTL, 8'h18);
    wr(ADDR_BUFFER, 8'hC3);
    lo = 1'b0;
    for (int k = 0; k < 2000 && irq_out !== 1'b1; k++)
    begin
      @(posedge clk);
      lo = lo | ~serial_out;
    end
    check("loop line", 8'h00, {7'h0, lo});
    rd(ADDR_BUFFER, 8'hC3);
    check("frames out", 8'h01, n_caught[7:0]);
    end_of_test();
  end
endmodule : uart_core_bench

//--- uart_line_model.sv
// serial line partner: sends 8n1 frames, catches frames from the port
`timescale 1ns/1ps
module uart_line_model
#(
  parameter int BIT_CYC = 48 // clocks per bit at divisor 3
)
(
  input  wire logic       clk,
  input  wire logic       line_from_dut,
  output logic            line_to_dut,
  output logic      [7:0] caught,
  output int              n_caught
);
  // line idles at mark, as a pulled-up wire would
  initial
  begin
    line_to_dut = 1'b1;
    caught      = 8'h00;
    n_caught    = 0;
  end

  // start low, data lsb first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_to_dut <= frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send

  // catcher samples mid-bit, far from the port's own edges
  always
  begin
    @(negedge line_from_dut);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      caught[i] = line_from_dut;
    end
    repeat (BIT_CYC) @(posedge clk);
    // only a frame with a proper stop bit counts
    if (line_from_dut === 1'b1)
      n_caught = n_caught + 1;
  end
endmodule : uart_line_model

//--- uart_pkg.sv
// shared constants and types of the serial port block
package uart_pkg;

  // register selects on the three address lines
  localparam logic [2:0] ADDR_BUFFER   = 3'h0; // rx/tx buffer, divisor low
  localparam logic [2:0] ADDR_IRQ_EN   = 3'h1; // irq enable, divisor high
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH  = 3'h7;

  // line control field positions
  localparam int LCR_STOP    = 2;
  localparam int LCR_PAR_EN  = 3;
  localparam int LCR_EVEN    = 4;
  localparam int LCR_STICK   = 5;
  localparam int LCR_BREAK   = 6;
  localparam int LCR_DIV_ACC = 7;

  // modem control field positions
  localparam int MCR_DTR     = 0;
  localparam int MCR_RTS     = 1;
  localparam int MCR_SOFT_RST = 2;
  localparam int MCR_IRQ_EN  = 3;
  localparam int MCR_LOOP    = 4;

  // interrupt status codes: none first, then sources highest priority first
  localparam logic [7:0] ISR_NONE  = 8'h01;
  localparam logic [7:0] ISR_LINE  = 8'h06;
  localparam logic [7:0] ISR_RX    = 8'h04;
  localparam logic [7:0] ISR_TX    = 8'h02;
  localparam logic [7:0] ISR_MODEM = 8'h00;

  // bit timing in 16x ticks (last index of each count)
  localparam int         OVERSAMPLE   = 16;
  localparam logic [4:0] BIT_LAST     = 5'h0F;
  localparam logic [4:0] START_SAMPLE = 5'h07; // 7.5 ticks after the edge
  localparam logic [4:0] STOP1_LAST   = 5'h0F;
  localparam logic [4:0] STOP15_LAST  = 5'h17;
  localparam logic [4:0] STOP2_LAST   = 5'h1F;
  localparam logic [2:0] WLEN_BASE    = 3'h4;  // five bits, last index

  // clock and baud range
  localparam int CLK_HZ      = 25000000;
  localparam int BAUD_MIN_HZ = 50;
  localparam int BAUD_MAX_HZ = 448000;
  localparam int DIV_AT_MAX  = CLK_HZ / (OVERSAMPLE * BAUD_MAX_HZ);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP}
    tx_phase_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
    rx_phase_type;

endpackage : uart_pkg
